// file: dv/pcsl_link_partner.sv
// remote link partner model: symbol stream source
`timescale 1ns/100ps
`default_nettype none
module pcsl_link_partner (
    // clock
    input  wire logic clk_i,
    // symbol stream
    output logic      sym_valid_o,
    output logic      sym_idle_o,
    output logic      sym_error_o,
    output logic      in_ipg_o
);
    logic v_q = 1'b0;
    logic i_q = 1'b0;
    logic g_q = 1'b0;
    logic t_q = 1'b0;
    // flags mean nothing between symbols, so they toggle
    always @(posedge clk_i) t_q <= ~t_q;
    assign sym_valid_o = v_q;
    assign sym_idle_o  = v_q ? i_q : t_q;
    assign sym_error_o = v_q ? ~i_q : ~t_q;
    assign in_ipg_o    = g_q;
    task automatic send(input int n, input logic idle, input logic ipg);
        repeat (n) begin
            @(posedge clk_i);
            v_q <= 1'b1;
            i_q <= idle;
            g_q <= ipg;
        end
        @(posedge clk_i);
        v_q <= 1'b0;
        g_q <= 1'b0;
    endtask : send
endmodule : pcsl_link_partner
`default_nettype wire

// file: dv/pcsl_lock_ctrl_chk.sv
// port checker for the lock control block
`timescale 1ns/100ps
`default_nettype none
module pcsl_lock_ctrl_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // apb and symbols
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic sym_valid_i,
    input wire logic sym_idle_i,
    input wire logic sym_error_i,
    // status
    input wire logic training_en_o,
    input wire logic descr_lock_o,
    input wire logic link_up_o,
    input wire logic remote_rx_ok_o
);
    wire logic wr_acc = psel_i & penable_i & pwrite_i;
    wire logic err_sym = sym_valid_i & sym_error_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_LOCK_IS_LINK: assert property (link_up_o == descr_lock_o)
        else $error("link differs from lock");
    AST_NO_TRAIN_LOCKED: assert property (!(training_en_o && descr_lock_o))
        else $error("training while locked");
    AST_LOCK_FROM_TRAIN: assert property ($rose(descr_lock_o) |-> $past(training_en_o))
        else $error("lock without training");
    AST_LOCK_ON_IDLE: assert property ($rose(descr_lock_o) |-> $past(sym_valid_i && sym_idle_i))
        else $error("lock without idle symbol");
    AST_LOSS_CAUSE: assert property ($fell(descr_lock_o) |->
        $past(err_sym) || $past(wr_acc) || $past(wr_acc, 2))
        else $error("lock lost without cause");
    AST_REM_CAUSE: assert property ($fell(remote_rx_ok_o) |->
        $past(err_sym) || $past(wr_acc) || $past(wr_acc, 2))
        else $error("remote status dropped without cause");
    AST_IDLE_HOLDS: assert property (descr_lock_o && sym_valid_i && sym_idle_i && !psel_i
        && !$past(psel_i) |=> descr_lock_o)
        else $error("idle symbol lost lock");
    AST_REM_ON_LOCK: assert property ($rose(descr_lock_o) |-> ##[0:1] remote_rx_ok_o)
        else $error("remote status not raised at lock");
endmodule : pcsl_lock_ctrl_chk
bind pcsl_lock_ctrl pcsl_lock_ctrl_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .sym_valid_i(sym_valid_i), .sym_idle_i(sym_idle_i), .sym_error_i(sym_error_i),
    .training_en_o(training_en_o), .descr_lock_o(descr_lock_o),
    .link_up_o(link_up_o), .remote_rx_ok_o(remote_rx_ok_o));
`default_nettype wire

// file: dv/pcsl_lock_ctrl_tb.sv
// testbench for the lock control block
`timescale 1ns/100ps
`default_nettype none
module pcsl_lock_ctrl_tb;
    import pcsl_pkg::*;
    logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] pstrb_i;
    logic pready_o, pslverr_o, sv, si, se, ig, tr, lk, lu, rr, er;
    int err_total = 0;
    int samples_checked = 0;
    pcsl_link_partner u_pcsl_link_partner (.clk_i(clk_i), .sym_valid_o(sv),
        .sym_idle_o(si), .sym_error_o(se), .in_ipg_o(ig));
    pcsl_lock_ctrl u_pcsl_lock_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sym_valid_i(sv), .sym_idle_i(si), .sym_error_i(se), .in_ipg_i(ig),
        .training_en_o(tr), .descr_lock_o(lk), .link_up_o(lu), .remote_rx_ok_o(rr));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // status settles a cycle after a write, so look two cycles on
    task automatic st(input logic [3:0] e);
        repeat (2) @(negedge clk_i);
        chk("status", e, {28'h0, rr, lu, lk, tr});
    endtask : st
    task automatic snd(input int n, input logic idle, input logic ipg);
        u_pcsl_link_partner.send(n, idle, ipg);
    endtask : snd
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        st(4'h1);
        apb(0, PCSL_ADDR_LINK_LOCK_CTRL, 0);
        chk("ctrl1", 32'h1078, rd);
        apb(0, PCSL_ADDR_LOSS_ERR_CTRL, 0);
        chk("ctrl2", 32'h1405, rd);
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'hFFFF);
        apb(0, PCSL_ADDR_LINK_LOCK_CTRL, 0);
        chk("ctrl1 mask", 32'hF1FF, rd);
        apb(0, 16'h0000, 0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'h1008);
        apb(1, PCSL_ADDR_LOSS_ERR_CTRL, 32'h0802);
        $display("test regs done");
    endtask : t_regs
    task automatic t_lock;
        snd(7, 1, 0);
        st(4'h1);
        snd(1, 0, 0);
        snd(7, 1, 0);
        st(4'h1);
        snd(1, 1, 0);
        st(4'hE);
        apb(0, PCSL_ADDR_LOCK_STATUS, 0);
        chk("lock status", 32'h27, rd);
        $display("test lock done");
    endtask : t_lock
    task automatic t_loss;
        snd(2, 0, 0);
        st(4'h6);
        // an idle while locked restores remote status and restarts the error run
        snd(1, 1, 0);
        st(4'hE);
        snd(2, 0, 0);
        st(4'h6);
        snd(1, 0, 0);
        st(4'h6);
        snd(1, 0, 0);
        st(4'h1);
        $display("test loss done");
    endtask : t_loss
    task automatic t_ipg;
        snd(8, 1, 0);
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'h3008);
        snd(6, 0, 1);
        st(4'hE);
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'h1008);
        snd(4, 0, 1);
        st(4'h1);
        $display("test ipg done");
    endtask : t_ipg
    task automatic t_link;
        snd(8, 1, 0);
        st(4'hE);
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'h0008);
        st(4'h0);
        snd(8, 1, 0);
        st(4'h0);
        apb(1, PCSL_ADDR_LINK_LOCK_CTRL, 32'h1008);
        st(4'h1);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        st(4'h1);
        apb(0, PCSL_ADDR_LINK_LOCK_CTRL, 0);
        chk("ctrl1 after reset", 32'h1078, rd);
        $display("test link done");
    endtask : t_link
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #(40 * 4000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {arst_n_i, psel_i, penable_i, pwrite_i} = 4'h0;
        paddr_i = 16'h0000;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_lock();
        t_loss();
        t_ipg();
        t_link();
        tally_and_finish();
    end
endmodule : pcsl_lock_ctrl_tb
`default_nettype wire

// file: verilog/pcsl_lock_ctrl.sv
// descrambler lock control with its apb register file
`timescale 1ns/100ps
`default_nettype none
module pcsl_lock_ctrl
    import pcsl_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // received symbol stream from the descrambler
    input  wire logic              sym_valid_i,
    input  wire logic              sym_idle_i,
    input  wire logic              sym_error_i,
    input  wire logic              in_ipg_i,
    // link status
    output logic                   training_en_o,
    output logic                   descr_lock_o,
    output logic                   link_up_o,
    output logic                   remote_rx_ok_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pcsl_state_t  fsm;
        logic [15:0]  ctrl1;
        logic [15:0]  ctrl2;
        logic         rem_ok;
        logic [31:0]  rdata;
    } pcsl_state_q_t;

    pcsl_state_q_t s_q;
    pcsl_state_q_t s_d;

    logic [PCSL_LOCK_CNT_W-1:0] idle_cnt;
    logic [PCSL_ERR_CNT_W-1:0]  err_cnt;
    logic                       idle_clr;
    logic                       idle_inc;
    logic                       err_clr;
    logic                       err_inc;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode, used for read and write

    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [1:0] r;
        r = 2'h0;
        if (a == ADDR_W'(PCSL_ADDR_LINK_LOCK_CTRL)) begin
            r = 2'h1;
        end else if (a == ADDR_W'(PCSL_ADDR_LOSS_ERR_CTRL)) begin
            r = 2'h2;
        end else if (a == ADDR_W'(PCSL_ADDR_LOCK_STATUS)) begin
            r = 2'h3;
        end
        return r;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] wdata,
        input logic [3:0]  strb,
        input logic [15:0] wmask
    );
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~m) | (wdata[15:0] & m);
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////////
    // field views

    logic                       link_ctrl;
    logic                       ipg_chk_dis;
    logic [PCSL_LOCK_CNT_W-1:0] lock_thr;
    logic [PCSL_ERR_CNT_W-1:0]  err_thr;
    logic [PCSL_REM_CNT_W-1:0]  rem_thr;
    logic                       err_seen;
    logic                       lock_hit;
    logic                       loss_hit;
    logic                       rem_hit;
    logic [1:0]                 sel;
    logic                       wr_acc;

    assign link_ctrl   = s_q.ctrl1[PCSL_LINK_CTRL_BIT];
    assign ipg_chk_dis = s_q.ctrl1[PCSL_IPG_CHK_DIS_BIT];
    assign lock_thr    = s_q.ctrl1[PCSL_LOCK_CNT_LSB +: PCSL_LOCK_CNT_W];
    assign err_thr     = s_q.ctrl2[PCSL_ERR_CNT_LSB +: PCSL_ERR_CNT_W];
    assign rem_thr     = s_q.ctrl2[PCSL_REM_CNT_LSB +: PCSL_REM_CNT_W];

    // errors in a gap are ignored when the gap check is off
    assign err_seen = sym_valid_i && sym_error_i
                      && !(in_ipg_i && ipg_chk_dis);

    // a threshold of zero behaves as one so the first symbol decides
    assign lock_hit = sym_valid_i && sym_idle_i
                      && (({1'b0, idle_cnt} + 10'h001) >= {1'b0, lock_thr});
    assign loss_hit = err_seen
                      && (({1'b0, err_cnt} + 6'h01) >= {1'b0, err_thr});
    assign rem_hit  = err_seen
                      && (({1'b0, err_cnt} + 6'h01) >= {1'b0, rem_thr});

    // idle run counts toward lock; any other symbol restarts it
    assign idle_clr = (s_q.fsm != PCSL_ST_TRAIN) || (sym_valid_i && !sym_idle_i);
    assign idle_inc = sym_valid_i && sym_idle_i;
    // error run restarts on every good idle symbol
    assign err_clr  = (s_q.fsm != PCSL_ST_LOCK) || (sym_valid_i && sym_idle_i);
    assign err_inc  = err_seen;

    assign sel    = reg_sel(paddr_i);
    assign wr_acc = psel_i && penable_i && pwrite_i;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;

        // register writes take effect in the access phase
        if (wr_acc && (sel == 2'h1)) begin
            s_d.ctrl1 = merge16(s_q.ctrl1, pwdata_i, pstrb_i, PCSL_CTRL1_WMASK);
        end else if (wr_acc && (sel == 2'h2)) begin
            s_d.ctrl2 = merge16(s_q.ctrl2, pwdata_i, pstrb_i, PCSL_CTRL2_WMASK);
        end

        // read data captured in setup so it stands through the access phase
        if (psel_i && !penable_i && !pwrite_i) begin
            if (sel == 2'h1) begin
                s_d.rdata = {16'h0000, s_q.ctrl1};
            end else if (sel == 2'h2) begin
                s_d.rdata = {16'h0000, s_q.ctrl2};
            end else if (sel == 2'h3) begin
                s_d.rdata = 32'h0000_0000;
                s_d.rdata[PCSL_ST_LINK_BIT]  = (s_q.fsm == PCSL_ST_LOCK);
                s_d.rdata[PCSL_ST_LOCK_BIT]  = (s_q.fsm == PCSL_ST_LOCK);
                s_d.rdata[PCSL_ST_REM_BIT]   = s_q.rem_ok;
                s_d.rdata[PCSL_ST_STATE_LSB +: 2] = s_q.fsm;
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end

        case (s_q.fsm)
            PCSL_ST_OFF: begin
                s_d.rem_ok = 1'b0;
                if (link_ctrl) begin
                    s_d.fsm = PCSL_ST_TRAIN;
                end
            end
            PCSL_ST_TRAIN: begin
                s_d.rem_ok = 1'b0;
                if (!link_ctrl) begin
                    s_d.fsm = PCSL_ST_OFF;
                end else if (lock_hit) begin
                    s_d.fsm    = PCSL_ST_LOCK;
                    s_d.rem_ok = 1'b1;
                end
            end
            PCSL_ST_LOCK: begin
                if (!link_ctrl) begin
                    s_d.fsm    = PCSL_ST_OFF;
                    s_d.rem_ok = 1'b0;
                end else if (loss_hit) begin
                    s_d.fsm    = PCSL_ST_TRAIN;
                    s_d.rem_ok = 1'b0;
                end else if (rem_hit) begin
                    s_d.rem_ok = 1'b0;
                end else if (sym_valid_i && sym_idle_i) begin
                    s_d.rem_ok = 1'b1;
                end
            end
            default: begin
                s_d.fsm    = PCSL_ST_OFF;
                s_d.rem_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q.fsm    <= PCSL_ST_OFF;
            s_q.ctrl1  <= PCSL_CTRL1_RESET;
            s_q.ctrl2  <= PCSL_CTRL2_RESET;
            s_q.rem_ok <= 1'b0;
            s_q.rdata  <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // symbol counters

    pcsl_sym_cnt #(
        .W        (PCSL_LOCK_CNT_W)
    ) u_idle_cnt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .clr_i    (idle_clr),
        .inc_i    (idle_inc),
        .count_o  (idle_cnt)
    );

    pcsl_sym_cnt #(
        .W        (PCSL_ERR_CNT_W)
    ) u_err_cnt (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .clr_i    (err_clr),
        .inc_i    (err_inc),
        .count_o  (err_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states; unmapped addresses and status writes are refused
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i && penable_i
                            && ((sel == 2'h0) || (pwrite_i && (sel == 2'h3)));
    assign prdata_o       = s_q.rdata;
    assign training_en_o  = (s_q.fsm == PCSL_ST_TRAIN);
    assign descr_lock_o   = (s_q.fsm == PCSL_ST_LOCK);
    assign link_up_o      = (s_q.fsm == PCSL_ST_LOCK);
    assign remote_rx_ok_o = s_q.rem_ok;

endmodule : pcsl_lock_ctrl
`default_nettype wire

// file: verilog/pcsl_pkg.sv
// constants for the descrambler lock control block
package pcsl_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [11:0] PCSL_IDX_LINK_LOCK_CTRL  = 12'h485;
    localparam logic [11:0] PCSL_IDX_LOSS_ERR_CTRL   = 12'h486;
    localparam logic [11:0] PCSL_IDX_LOCK_STATUS     = 12'h4F0;
    localparam logic [15:0] PCSL_ADDR_LINK_LOCK_CTRL = {2'h0, PCSL_IDX_LINK_LOCK_CTRL, 2'h0};
    localparam logic [15:0] PCSL_ADDR_LOSS_ERR_CTRL  = {2'h0, PCSL_IDX_LOSS_ERR_CTRL, 2'h0};
    localparam logic [15:0] PCSL_ADDR_LOCK_STATUS    = {2'h0, PCSL_IDX_LOCK_STATUS, 2'h0};

    // link_lock_control fields
    localparam int unsigned PCSL_IPG_CHK_DIS_BIT = 13;
    localparam int unsigned PCSL_LINK_CTRL_BIT   = 12;
    localparam int unsigned PCSL_LOCK_CNT_LSB    = 0;
    localparam int unsigned PCSL_LOCK_CNT_W      = 9;
    localparam logic [15:0] PCSL_CTRL1_RESET     = 16'h1078;
    localparam logic [15:0] PCSL_CTRL1_WMASK     = 16'hF1FF;

    // lock_loss_error_control fields
    localparam int unsigned PCSL_ERR_CNT_LSB     = 9;
    localparam int unsigned PCSL_ERR_CNT_W       = 5;
    localparam int unsigned PCSL_REM_CNT_LSB     = 0;
    localparam int unsigned PCSL_REM_CNT_W       = 5;
    localparam logic [15:0] PCSL_CTRL2_RESET     = 16'h1405;
    localparam logic [15:0] PCSL_CTRL2_WMASK     = 16'hFFFF;

    // lock status fields
    localparam int unsigned PCSL_ST_LINK_BIT     = 0;
    localparam int unsigned PCSL_ST_LOCK_BIT     = 1;
    localparam int unsigned PCSL_ST_REM_BIT      = 2;
    localparam int unsigned PCSL_ST_STATE_LSB    = 4;

    typedef enum logic [1:0] {
        PCSL_ST_OFF   = 2'b00,
        PCSL_ST_TRAIN = 2'b01,
        PCSL_ST_LOCK  = 2'b10
    } pcsl_state_t;

endpackage : pcsl_pkg

// file: verilog/pcsl_sym_cnt.sv
// saturating symbol counter with synchronous clear
`timescale 1ns/100ps
`default_nettype none
module pcsl_sym_cnt #(
    parameter int unsigned W = 9
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // control
    input  wire logic         clr_i,
    input  wire logic         inc_i,
    // count
    output logic [W-1:0]      count_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } pcsl_cnt_state_t;

    pcsl_cnt_state_t s_q;
    pcsl_cnt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.cnt = '0;
        end else if (inc_i && (s_q.cnt != {W{1'b1}})) begin
            s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count_o = s_q.cnt;

endmodule : pcsl_sym_cnt
`default_nettype wire
